// ===== hw/rfl_frontend.sv
// module: rf front-end line control top with wishbone register slave
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps

module rfl_frontend
  import rfl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        tx_req_i,
  input  wire logic        rx_req_i,
  output logic             rx_indicator_line_o,
  output logic             tx_indicator_line_o,
  output logic             lines_used_o,
  output logic             pa_enable_o,
  output logic             int_ramp_active_o,
  output logic      [4:0]  int_ramp_level_o,
  output logic             carrier_o,
  output logic             modulate_o,
  output logic      [7:0]  dac_control_word_o,
  output logic             dac_enable_o
);
  // register file and bus answer
  logic [2:0]    rf_line_mode_setting_reg;
  logic [2:0]    rf_line_mode_setting_next;
  logic [15:0]   tx_ramp_delay_setting_reg;
  logic [15:0]   tx_ramp_delay_setting_next;
  logic [7:0]    dac_word_reg;
  logic [7:0]    dac_word_next;
  logic [1:0]    ctrl_reg;
  logic [1:0]    ctrl_next;
  logic [31:0]   dat_reg;
  logic [31:0]   dat_next;
  logic          ack_reg;
  logic          ack_next;
  logic          req_tx;
  logic          req_rx;

  // transmit sequencer
  logic          us_tick;
  rfl_tx_state_t st_reg;
  rfl_tx_state_t st_next;
  logic [4:0]    lvl_reg;
  logic [4:0]    lvl_next;
  logic [7:0]    hold_reg;
  logic [7:0]    hold_next;
  logic          tx_busy;

  // registered pins and dac word
  logic          pa_reg;
  logic          pa_next;
  logic          car_reg;
  logic          car_next;
  logic          mod_reg;
  logic          mod_next;
  logic          rmp_reg;
  logic          rmp_next;
  logic          rx_act_reg;
  logic          rx_act_next;
  logic          rxl_reg;
  logic          txl_reg;
  logic          used_reg;
  logic          rxl_c;
  logic          txl_c;
  logic          used_c;
  logic [7:0]    dacw_reg;
  logic [7:0]    dacw_next;
  logic          dace_reg;
  logic          dace_next;

  // free-running tick: the first ramp or hold step may be up to one us short
  rfl_us_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (us_tick)
  );

  // software can request tx/rx through the control register as well as the pins
  assign req_tx = tx_req_i | ctrl_reg[RFL_CTRL_TX];
  assign req_rx = rx_req_i | ctrl_reg[RFL_CTRL_RX];

  // wishbone slave: ack one cycle after strobe, dropped the following cycle
  // a write lands on the edge that raises ack; a read of it returns the old value
  always_comb begin
    rf_line_mode_setting_next  = rf_line_mode_setting_reg;
    tx_ramp_delay_setting_next = tx_ramp_delay_setting_reg;
    dac_word_next              = dac_word_reg;
    ctrl_next                  = ctrl_reg;
    dat_next                   = dat_reg;
    ack_next                   = 1'b0;
    if (cyc_i && stb_i && !ack_reg) begin
      ack_next = 1'b1;
      dat_next = 32'h0000_0000;
      case (adr_i)
        RFL_MODE_OFF: begin
          dat_next[2:0] = rf_line_mode_setting_reg;
          if (we_i && sel_i[0]) begin
            rf_line_mode_setting_next = dat_i[2:0];
          end
        end
        RFL_RAMP_OFF: begin
          dat_next[15:0] = tx_ramp_delay_setting_reg;
          if (we_i && sel_i[0]) begin
            tx_ramp_delay_setting_next[7:0] = dat_i[7:0];
          end
          if (we_i && sel_i[1]) begin
            tx_ramp_delay_setting_next[15:8] = dat_i[15:8];
          end
        end
        RFL_DAC_OFF: begin
          dat_next[7:0] = dac_word_reg;
          if (we_i && sel_i[0]) begin
            dac_word_next = dat_i[7:0];
          end
        end
        RFL_STATUS_OFF: begin
          dat_next[2:0]  = st_reg;
          dat_next[7:3]  = lvl_reg;
          dat_next[15:8] = hold_reg;
          dat_next[16]   = pa_reg;
          dat_next[17]   = car_reg;
          dat_next[18]   = mod_reg;
          dat_next[19]   = rx_act_reg;
        end
        RFL_CTRL_OFF: begin
          dat_next[1:0] = ctrl_reg;
          if (we_i && sel_i[0]) begin
            ctrl_next = dat_i[1:0];
          end
        end
        default: begin
          dat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // transmit sequencer; receive is refused while a transmit is under way
  assign tx_busy = (st_reg != TX_IDLE);

  always_comb begin
    st_next     = st_reg;
    lvl_next    = lvl_reg;
    hold_next   = hold_reg;
    rx_act_next = req_rx && !req_tx && !tx_busy;
    case (st_reg)
      TX_IDLE: begin
        lvl_next = 5'h00;
        if (req_tx) begin
          st_next = TX_RAMP_UP;
        end
      end
      TX_RAMP_UP: begin
        // external ramp: the pa ramps itself, so skip the internal steps
        if (!rfl_ramp_internal(rf_line_mode_setting_reg)) begin
          st_next   = TX_CARRIER;
          hold_next = tx_ramp_delay_setting_reg[RFL_HOLD_MSB:RFL_HOLD_LSB];
        end else if (us_tick) begin
          if (lvl_reg == RAMP_STEPS_M1) begin
            st_next   = TX_CARRIER;
            hold_next = tx_ramp_delay_setting_reg[RFL_HOLD_MSB:RFL_HOLD_LSB];
          end else begin
            lvl_next = lvl_reg + 5'h01;
          end
        end
      end
      TX_CARRIER: begin
        // a hold of zero still gives one cycle of carrier
        if (hold_reg == 8'h00) begin
          st_next = TX_MOD;
        end else if (us_tick) begin
          hold_next = hold_reg - 8'h01;
        end
      end
      TX_MOD: begin
        if (!req_tx) begin
          st_next = TX_RAMP_DN;
        end
      end
      TX_RAMP_DN: begin
        if (!rfl_ramp_internal(rf_line_mode_setting_reg) || lvl_reg == 5'h00) begin
          st_next  = TX_IDLE;
          lvl_next = 5'h00;
        end else if (us_tick) begin
          lvl_next = lvl_reg - 5'h01;
        end
      end
      default: begin
        st_next = TX_IDLE;
      end
    endcase
    pa_next   = (st_next != TX_IDLE);
    car_next  = (st_next == TX_CARRIER);
    mod_next  = (st_next == TX_MOD);
    rmp_next  = rfl_ramp_internal(rf_line_mode_setting_reg) &&
                (st_next == TX_RAMP_UP || st_next == TX_RAMP_DN);
    // an unused dac is parked at code zero so an attached pa sees no stray gain
    dace_next = rfl_dac_used(rf_line_mode_setting_reg);
    dacw_next = dace_next ? dac_word_reg : 8'h00;
  end

  // fed from next-state values so the lines switch on the same edge as pa enable
  rfl_line_drive u_lines (
    .mode_i       (rf_line_mode_setting_reg),
    .rx_i         (rx_act_next),
    .tx_i         (pa_next),
    .rx_line_o    (rxl_c),
    .tx_line_o    (txl_c),
    .lines_used_o (used_c)
  );

  // register file and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rf_line_mode_setting_reg  <= RFL_MODE_RST;
      tx_ramp_delay_setting_reg <= RFL_RAMP_RST;
      dac_word_reg              <= RFL_DAC_RST;
      ctrl_reg                  <= 2'h0;
      dat_reg                   <= 32'h0000_0000;
      ack_reg                   <= 1'b0;
    end else begin
      rf_line_mode_setting_reg  <= rf_line_mode_setting_next;
      tx_ramp_delay_setting_reg <= tx_ramp_delay_setting_next;
      dac_word_reg              <= dac_word_next;
      ctrl_reg                  <= ctrl_next;
      dat_reg                   <= dat_next;
      ack_reg                   <= ack_next;
    end
  end

  // transmit sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg   <= TX_IDLE;
      lvl_reg  <= 5'h00;
      hold_reg <= 8'h00;
    end else begin
      st_reg   <= st_next;
      lvl_reg  <= lvl_next;
      hold_reg <= hold_next;
    end
  end

  // registered pins and dac word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_reg     <= 1'b0;
      car_reg    <= 1'b0;
      mod_reg    <= 1'b0;
      rmp_reg    <= 1'b0;
      rx_act_reg <= 1'b0;
      rxl_reg    <= 1'b0;
      txl_reg    <= 1'b0;
      used_reg   <= 1'b0;
      dacw_reg   <= 8'h00;
      dace_reg   <= 1'b0;
    end else begin
      pa_reg     <= pa_next;
      car_reg    <= car_next;
      mod_reg    <= mod_next;
      rmp_reg    <= rmp_next;
      rx_act_reg <= rx_act_next;
      rxl_reg    <= rxl_c;
      txl_reg    <= txl_c;
      used_reg   <= used_c;
      dacw_reg   <= dacw_next;
      dace_reg   <= dace_next;
    end
  end

  assign dat_o               = dat_reg;
  assign ack_o               = ack_reg;
  assign rx_indicator_line_o = rxl_reg;
  assign tx_indicator_line_o = txl_reg;
  assign lines_used_o        = used_reg;
  assign pa_enable_o         = pa_reg;
  assign int_ramp_active_o   = rmp_reg;
  assign int_ramp_level_o    = lvl_reg;
  assign carrier_o           = car_reg;
  assign modulate_o          = mod_reg;
  assign dac_control_word_o  = dacw_reg;
  assign dac_enable_o        = dace_reg;
endmodule // rfl_frontend

// ===== hw/rfl_pkg.sv
// package: constants and types for the rf front-end line control block
package rfl_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] RFL_MODE_OFF   = 8'h00;
  localparam logic [7:0] RFL_RAMP_OFF   = 8'h04;
  localparam logic [7:0] RFL_DAC_OFF    = 8'h08;
  localparam logic [7:0] RFL_STATUS_OFF = 8'h0C;
  localparam logic [7:0] RFL_CTRL_OFF   = 8'h10;
  // reset values
  localparam logic [2:0]  RFL_MODE_RST = 3'h0;
  localparam logic [15:0] RFL_RAMP_RST = 16'h0000;
  localparam logic [7:0]  RFL_DAC_RST  = 8'h00;
  // field positions
  localparam int RFL_HOLD_MSB = 15;
  localparam int RFL_HOLD_LSB = 8;
  localparam int RFL_CTRL_TX  = 0;
  localparam int RFL_CTRL_RX  = 1;
  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int US_NS           = 1000;
  localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int US_CYCLES       = US_NS / CLK_PERIOD_NS;
  localparam logic [5:0] US_CYCLES_M1 = 6'(US_CYCLES - 1);
  localparam int RAMP_STEPS      = 16;
  localparam logic [4:0] RAMP_STEPS_M1 = 5'(RAMP_STEPS - 1);
  localparam logic [7:0] DAC_FULL_CODE = 8'hFF;

  typedef enum logic [2:0] {
    TX_IDLE    = 3'b000,
    TX_RAMP_UP = 3'b001,
    TX_CARRIER = 3'b011,
    TX_MOD     = 3'b010,
    TX_RAMP_DN = 3'b110
  } rfl_tx_state_t;

  // internal ramp applies in modes 0,1,4 and in any unlisted mode
  function automatic logic rfl_ramp_internal(input logic [2:0] m);
    return !(m == 3'h2 || m == 3'h3);
  endfunction

  function automatic logic rfl_dac_used(input logic [2:0] m);
    return (m == 3'h2 || m == 3'h3 || m == 3'h4);
  endfunction
endpackage

// ===== hw/rfl_us_tick.sv
// module: one-microsecond enable pulse divider
`timescale 1ns/100ps
module rfl_us_tick
  import rfl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;

  always_comb begin
    tick_next = (cnt_reg == US_CYCLES_M1);
    cnt_next  = tick_next ? 6'h00 : cnt_reg + 6'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule // rfl_us_tick

// ===== hw/rfl_line_drive.sv
// module: indicator line levels from mode and radio direction
`timescale 1ns/100ps
module rfl_line_drive
  import rfl_pkg::*;
(
  input  wire logic [2:0] mode_i,
  input  wire logic       rx_i,
  input  wire logic       tx_i,
  output logic            rx_line_o,
  output logic            tx_line_o,
  output logic            lines_used_o
);
  always_comb begin
    rx_line_o    = 1'b0;
    tx_line_o    = 1'b0;
    lines_used_o = 1'b1;
    case (mode_i)
      3'h1, 3'h2, 3'h4: begin
        rx_line_o = rx_i;
        tx_line_o = tx_i;
      end
      3'h3: begin
        rx_line_o = !rx_i;
        tx_line_o = !tx_i;
      end
      default: begin
        lines_used_o = 1'b0;
      end
    endcase
  end
endmodule // rfl_line_drive

// ===== verification/rfl_frontend_monitor.sv
// checker: concurrent assertions on the front-end line control ports
`timescale 1ns/100ps
module rfl_frontend_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       rx_indicator_line_o,
  input wire logic       tx_indicator_line_o,
  input wire logic       lines_used_o,
  input wire logic       pa_enable_o,
  input wire logic       int_ramp_active_o,
  input wire logic [4:0] int_ramp_level_o,
  input wire logic       carrier_o,
  input wire logic       modulate_o,
  input wire logic [7:0] dac_control_word_o,
  input wire logic       dac_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pa_gates_rf_a: assert property (!pa_enable_o |-> !carrier_o && !modulate_o)
    else $error("carrier or modulation without pa enable");
  unused_lines_a: assert property (!lines_used_o |-> !rx_indicator_line_o && !tx_indicator_line_o)
    else $error("lines driven while unused");
  tx_line_level_a: assert property (
    $past(pa_enable_o, 2) && pa_enable_o && lines_used_o
    |-> tx_indicator_line_o != rx_indicator_line_o)
    else $error("tx line not active during transmit");
  dac_idle_word_a: assert property (!dac_enable_o |-> dac_control_word_o == 8'h00)
    else $error("dac word nonzero while unused");
  ramp_step_a: assert property (
    $changed(int_ramp_level_o) |-> int_ramp_level_o == $past(int_ramp_level_o) + 5'h01 ||
    int_ramp_level_o == $past(int_ramp_level_o) - 5'h01)
    else $error("ramp level jumped");
  ramp_ceiling_a: assert property (int_ramp_level_o <= 5'h0F)
    else $error("ramp level above top");
  carrier_start_a: assert property (
    $rose(carrier_o) |-> pa_enable_o && !modulate_o ##1 (carrier_o != modulate_o))
    else $error("carrier did not precede modulation");
  mod_after_carrier_a: assert property ($rose(modulate_o) |-> $past(carrier_o))
    else $error("modulation started without carrier");
  ramp_flag_state_a: assert property (
    int_ramp_active_o |-> pa_enable_o && !carrier_o && !modulate_o)
    else $error("internal ramp outside ramp phase");
  ramp_down_end_a: assert property ($fell(pa_enable_o) |-> int_ramp_level_o == 5'h00)
    else $error("pa dropped before ramp down done");
endmodule // rfl_frontend_monitor

bind rfl_frontend rfl_frontend_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .rx_indicator_line_o(rx_indicator_line_o),
  .tx_indicator_line_o(tx_indicator_line_o), .lines_used_o(lines_used_o),
  .pa_enable_o(pa_enable_o), .int_ramp_active_o(int_ramp_active_o),
  .int_ramp_level_o(int_ramp_level_o), .carrier_o(carrier_o),
  .modulate_o(modulate_o), .dac_control_word_o(dac_control_word_o), .dac_enable_o(dac_enable_o));

// ===== verification/rfl_frontend_peer.sv
// partner: external power amplifier driven by enable and gain voltage
`timescale 1ns/100ps
module rfl_frontend_peer (
  input  wire logic       pa_enable_i,
  input  wire logic       dac_enable_i,
  input  wire logic [7:0] dac_word_i,
  output logic      [7:0] pa_gain_o
);
  // amplifier passes nothing unless enabled; gain pin floats low without dac
  assign pa_gain_o = (pa_enable_i && dac_enable_i) ? dac_word_i : 8'h00;
endmodule // rfl_frontend_peer

// ===== verification/rfl_frontend_test.sv
// testbench: self-checking bench for the front-end line control block
`timescale 1ns/100ps
module rfl_frontend_test;
  import rfl_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, tx_req_i = 0, rx_req_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, rxl, txl, used, pa, ract, car, modu, den;
  logic [4:0] lvl;
  logic [7:0] dw, gain;
  int error_cnt = 0, cmp_count = 0, cyc_n = 0, n;
  logic ext_seen;
  // per mode: idle rx, idle tx, rx active level, lines used, dac used
  localparam logic [4:0] ROWS [8] = '{5'h00, 5'h06, 5'h07, 5'h1B, 5'h07, 5'h00, 5'h00, 5'h00};
  rfl_frontend dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_req_i(tx_req_i), .rx_req_i(rx_req_i), .rx_indicator_line_o(rxl),
    .tx_indicator_line_o(txl), .lines_used_o(used), .pa_enable_o(pa),
    .int_ramp_active_o(ract), .int_ramp_level_o(lvl), .carrier_o(car), .modulate_o(modu),
    .dac_control_word_o(dw), .dac_enable_o(den));
  rfl_frontend_peer peer (.pa_enable_i(pa), .dac_enable_i(den), .dac_word_i(dw), .pa_gain_o(gain));
  always #10 clk_i = ~clk_i;
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= we; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task wait_for(input int lim, input logic for_mod);
    n = 0;
    while (n < lim && (for_mod ? modu : car) !== 1'b1) begin
      @(posedge clk_i); n++;
      if (ract === 1'b1) ext_seen = 1;
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk({rxl, txl, pa, dw}, 0, "reset outputs");
    wb(1, RFL_DAC_OFF, 32'h0000_00FF);
    for (int m = 0; m < 8; m++) begin
      wb(1, RFL_MODE_OFF, m);
      repeat (2) @(posedge clk_i);
      chk({rxl, txl}, ROWS[m][4:3], "idle lines");
      chk({used, den}, ROWS[m][1:0], "line and dac use");
      chk(dw, ROWS[m][0] ? DAC_FULL_CODE : 8'h00, "dac word");
      rx_req_i <= 1;
      repeat (3) @(posedge clk_i);
      chk(rxl, ROWS[m][2], "rx line during receive");
      rx_req_i <= 0;
      $display("mode %0d done", m);
    end
    wb(1, RFL_MODE_OFF, 32'h1);
    wb(1, RFL_CTRL_OFF, 32'h2);
    wb(0, RFL_STATUS_OFF, 32'h0);
    chk(q, 32'h0008_0000, "status shows software rx");
    chk(rxl, 1'b1, "rx line from control bit");
    wb(1, RFL_CTRL_OFF, 32'h0);
    wb(1, RFL_RAMP_OFF, 32'h0000_0300);
    wb(0, RFL_RAMP_OFF, 32'h0);
    chk(q, 32'h0000_0300, "ramp setting read back");
    $display("control register test done");
    tx_req_i <= 1;
    wait_for(3000, 1'b0);
    chk(lvl, 5'h0F, "ramp top before carrier");
    chk(txl, 1'b1, "tx line high");
    chk(modu, 1'b0, "no modulation at carrier start");
    wait_for(1000, 1'b1);
    chk(n >= 150 && n <= 202, 1, "carrier hold time");
    chk(gain, 8'h00, "no dac gain in mode 1");
    tx_req_i <= 0;
    n = 0;
    while (pa !== 1'b0 && n < 3000) begin @(posedge clk_i); n++; end
    chk({pa, lvl}, 0, "ramp down then pa off");
    $display("internal ramp test done");
    wb(1, RFL_MODE_OFF, 32'h3);
    wb(1, RFL_RAMP_OFF, 32'h0);
    ext_seen = 0;
    tx_req_i <= 1;
    wait_for(20, 1'b1);
    chk(ext_seen, 1'b0, "no internal ramp in mode 3");
    chk({txl, gain}, {1'b0, DAC_FULL_CODE}, "low tx line, dac gain");
    tx_req_i <= 0;
    repeat (10) @(posedge clk_i);
    chk(pa, 1'b0, "pa off after external ramp");
    wb(0, 8'hFC, 32'h0);
    chk(q, 32'h0, "unmapped read");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, RFL_MODE_OFF, 32'h0);
    chk(q, 32'h0, "mode after reset");
    $display("external ramp and reset test done");
    wrap_up;
  end
endmodule // rfl_frontend_test
